//--- logic/sep_slave.sv
// Purpose: Two-wire serial slave with 16K byte memory and page write buffer
// Assumes: Bus clock and data are sampled by core_clk and synchronised
// Notes:   Memory starts erased; write cycle length is a parameter
// Operation
// RULE_01 - Sample data on bus clock rise, change output after its fall
// RULE_02 - Send zero by pulling data low, one by releasing it
// RULE_03 - Master keeps data stable while clock high and starts only when idle
// RULE_04 - Data fall with clock high is START, rise is STOP
// RULE_05 - Ignore all traffic until a START is seen
// RULE_06 - Slave address: type code, three select pins, then read bit
// RULE_07 - Acknowledge matching address, address bytes and write data in ninth clock
// RULE_08 - Read mode shifts a byte, releases ninth clock, continues on master acknowledge
// RULE_09 - Two address bytes load counter; top two bits ignored
// RULE_10 - Data bytes go to page buffer; STOP after data starts write
// RULE_11 - During write cycle keep data released and ignore requests
// RULE_12 - Accept up to 64 bytes, commit all in one cycle
// RULE_13 - Page fixed, offset wraps; later bytes overwrite, latest sequence only
// RULE_14 - Do not acknowledge slave address while write busy
// RULE_15 - Write protect high blocks all writes; low has no effect
// RULE_16 - Sample protect on last fall before first data; reject if high
// RULE_17 - Memory starts with every byte erased to FFh
// RULE_18 - Read address acknowledged, then byte at counter shifted out
// RULE_19 - Selective read loads all fourteen address bits then reads there
// RULE_20 - Sequential read increments counter, wrapping at end of memory
// RULE_21 - After reset enter standby waiting for START
// RULE_22 - Internal write duration is a parameter in core clocks
// RULE_23 - STOP with no data loaded starts no write cycle
module sep_slave
    import sep_pkg::*;
#(
    parameter int unsigned WRITE_TICKS = WRITE_CYCLES,
    parameter logic [3:0]  TYPE_CODE   = TYPE_CODE_DEFAULT
)
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic       wp_in,
    input  wire logic       addr_select_bit0,
    input  wire logic       addr_select_bit1,
    input  wire logic       addr_select_bit2,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            write_busy
);
    import sep_pkg::*;

    typedef struct packed {
        sep_phase_e        phase;
        logic [3:0]        bitn;
        logic [7:0]        shreg;
        logic              rdir;
        logic              ack_hold;
        logic              nak;
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] base;
        logic [6:0]        loaded;
        logic              protect;
        logic              busy;
        logic [31:0]       wcount;
        logic [6:0]        cidx;
        sep_drive_s        drv;
        logic [2:0]        sel1;
        logic [2:0]        sel;
    } sep_state_s;

    sep_state_s st;
    sep_state_s next_st;
    sep_pins_s  pin_raw;
    sep_pins_s  pin_now;
    sep_pins_s  pin_last;

    logic [7:0]        mem [0:MEM_BYTES-1];
    logic [7:0]        pbuf [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] pvalid;
    logic [PAGE_BYTES-1:0] next_pvalid;
    logic              init_done;
    logic [ADDR_W-1:0] init_addr;
    logic              buf_we;
    logic [OFS_W-1:0]  buf_ofs;
    logic              mem_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [7:0]        rd_byte;

    assign pin_raw = '{scl: scl_in, sda: sda_in, wp: wp_in};

    sep_sync u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .pin      (pin_raw),
        .now      (pin_now),
        .last     (pin_last)
    );

    wire scl_rise = pin_now.scl & ~pin_last.scl;
    wire scl_fall = ~pin_now.scl & pin_last.scl;
    wire start_c  = pin_now.scl & pin_last.scl & pin_last.sda & ~pin_now.sda; // [RULE_04]
    wire stop_c   = pin_now.scl & pin_last.scl & ~pin_last.sda & pin_now.sda; // [RULE_04]

    function automatic logic [ADDR_W-1:0] page_step(input logic [ADDR_W-1:0] a);
        page_step = {a[ADDR_W-1:OFS_W], a[OFS_W-1:0] + 6'h01}; // [RULE_13]
    endfunction

    always_comb
    begin
        next_st     = st;
        next_pvalid = pvalid;
        buf_we      = 1'b0;
        buf_ofs     = st.addr[OFS_W-1:0];
        mem_we      = 1'b0;
        mem_wa      = st.base;
        next_st.sel1 = {addr_select_bit2, addr_select_bit1, addr_select_bit0};
        next_st.sel  = st.sel1;
        if (st.busy)
        begin
            next_st.drv = '{sda_out: 1'b1, sda_oe: 1'b0}; // [RULE_11]
            if (pvalid[st.cidx[OFS_W-1:0]] && !st.cidx[6])
            begin
                mem_we = 1'b1;
                mem_wa = {st.base[ADDR_W-1:OFS_W], st.cidx[OFS_W-1:0]};
            end
            if (!st.cidx[6])
            begin
                next_pvalid[st.cidx[OFS_W-1:0]] = 1'b0;
                next_st.cidx = st.cidx + 7'h01; // [RULE_12]
            end
            if (st.wcount >= WRITE_TICKS - 1) // [RULE_22]
            begin
                next_st.busy = 1'b0;
            end
            else
            begin
                next_st.wcount = st.wcount + 32'h1;
            end
        end
        if (start_c)
        begin
            next_st.phase = st.busy ? SEP_IGNORE : SEP_DEVADR; // [RULE_05] [RULE_14]
            // Clock fall that follows START wraps the count to zero
            next_st.bitn  = 4'hf;
            next_st.drv   = '{sda_out: 1'b1, sda_oe: 1'b0};
        end
        else if (stop_c)
        begin
            if (st.phase == SEP_WDATA && st.loaded != 7'h00 && !st.protect) // [RULE_10] [RULE_23]
            begin
                next_st.busy   = 1'b1;
                next_st.wcount = 32'h0;
                next_st.cidx   = 7'h00;
            end
            // A STOP while busy must not drop bytes not yet committed
            else if (st.phase != SEP_RDATA && !st.busy)
            begin
                next_pvalid = '0;
            end
            next_st.phase = SEP_IDLE;
            next_st.drv   = '{sda_out: 1'b1, sda_oe: 1'b0};
        end
        else if (st.phase != SEP_IDLE && st.phase != SEP_IGNORE)
        begin
            if (scl_rise) // [RULE_01]
            begin
                if (st.bitn == ACK_BIT[3:0])
                begin
                    next_st.nak = pin_now.sda;
                end
                else
                begin
                    next_st.shreg = {st.shreg[6:0], pin_now.sda};
                end
            end
            if (scl_fall) // [RULE_01]
            begin
                next_st.bitn = st.bitn + 4'h1;
                next_st.drv  = '{sda_out: 1'b1, sda_oe: 1'b0}; // [RULE_02]
                if (st.bitn == 4'h7 && !(st.phase == SEP_RDATA))
                begin
                    next_st.ack_hold = 1'b1;
                    case (st.phase)
                        SEP_DEVADR:
                        begin
                            if (st.shreg[7:4] == TYPE_CODE && st.shreg[3:1] == st.sel) // [RULE_06]
                            begin
                                next_st.rdir = st.shreg[0];
                                next_st.drv  = '{sda_out: 1'b0, sda_oe: 1'b1}; // [RULE_07]
                            end
                            else
                            begin
                                next_st.ack_hold = 1'b0;
                                next_st.phase    = SEP_IGNORE;
                            end
                        end
                        SEP_ADRHI:
                        begin
                            next_st.addr[ADDR_W-1:8] = st.shreg[5:0]; // [RULE_09]
                            next_st.drv = '{sda_out: 1'b0, sda_oe: 1'b1};
                        end
                        SEP_ADRLO:
                        begin
                            next_st.addr[7:0] = st.shreg; // [RULE_09] [RULE_19]
                            next_st.base      = {st.addr[ADDR_W-1:8], st.shreg};
                            next_st.drv       = '{sda_out: 1'b0, sda_oe: 1'b1};
                        end
                        SEP_WDATA:
                        begin
                            if (!st.protect) // [RULE_15] [RULE_16]
                            begin
                                buf_we = 1'b1;
                                next_pvalid[st.addr[OFS_W-1:0]] = 1'b1;
                                next_st.addr   = page_step(st.addr); // [RULE_13]
                                next_st.loaded = (st.loaded == 7'd64) ? st.loaded : st.loaded + 7'h01;
                                next_st.drv    = '{sda_out: 1'b0, sda_oe: 1'b1};
                            end
                            else
                            begin
                                next_st.ack_hold = 1'b0;
                            end
                        end
                        default:
                        begin
                            next_st.ack_hold = 1'b0;
                        end
                    endcase
                end
                else if (st.bitn == ACK_BIT[3:0])
                begin
                    next_st.bitn     = 4'h0;
                    next_st.ack_hold = 1'b0;
                    case (st.phase)
                        SEP_DEVADR:
                        begin
                            if (st.rdir)
                            begin
                                next_st.phase = SEP_RDATA; // [RULE_18]
                                next_st.drv   = '{sda_out: rd_byte[7], sda_oe: ~rd_byte[7]}; // [RULE_02]
                            end
                            else
                            begin
                                next_st.phase = SEP_ADRHI;
                                next_pvalid   = '0; // [RULE_13]
                                next_st.loaded = 7'h00;
                            end
                        end
                        SEP_ADRHI:
                        begin
                            next_st.phase = SEP_ADRLO;
                        end
                        SEP_ADRLO:
                        begin
                            next_st.phase   = SEP_WDATA;
                            next_st.protect = pin_now.wp; // [RULE_16]
                        end
                        SEP_RDATA:
                        begin
                            if (st.nak)
                            begin
                                next_st.phase = SEP_IGNORE; // [RULE_08]
                            end
                            else
                            begin
                                next_st.drv = '{sda_out: rd_byte[7], sda_oe: ~rd_byte[7]};
                            end
                        end
                        default:
                        begin
                        end
                    endcase
                end
                else if (st.phase == SEP_RDATA)
                begin
                    if (st.bitn == 4'h7)
                    begin
                        next_st.addr = st.addr + 14'h0001; // [RULE_20]
                    end
                    else
                    begin
                        next_st.drv = '{sda_out: rd_byte[3'd6 - st.bitn[2:0]],
                                        sda_oe: ~rd_byte[3'd6 - st.bitn[2:0]]}; // [RULE_08]
                    end
                end
            end
        end
    end

    assign rd_byte = mem[st.addr];

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            st     <= '{phase: SEP_IDLE, addr: ADDR_RESET, base: ADDR_RESET, bitn: 4'h0,
                        drv: '{sda_out: 1'b1, sda_oe: 1'b0}, cidx: 7'h40, default: '0}; // [RULE_21]
            pvalid <= '0;
        end
        else
        begin
            st     <= next_st;
            pvalid <= next_pvalid;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (buf_we)
        begin
            pbuf[buf_ofs] <= st.shreg;
        end
        if (!init_done)
        begin
            mem[init_addr] <= ERASED_BYTE; // [RULE_17]
        end
        else if (mem_we)
        begin
            mem[mem_wa] <= pbuf[mem_wa[OFS_W-1:0]];
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            init_done <= 1'b0;
            init_addr <= ADDR_RESET;
        end
        else if (!init_done)
        begin
            init_addr <= init_addr + 14'h0001;
            init_done <= (init_addr == 14'h3fff);
        end
    end

    assign sda_out    = st.drv.sda_out;
    assign sda_oe     = st.drv.sda_oe;
    assign write_busy = st.busy;

    a_busy_release: assert property (@(posedge core_clk) disable iff (reset)
        st.busy |-> !sda_oe) else $error("Data driven during write cycle"); // [RULE_11]
    a_stop_write: assert property (@(posedge core_clk) disable iff (reset)
        (stop_c && st.phase == SEP_WDATA && st.loaded != 7'h00 && !st.protect && !start_c) |=> st.busy)
        else $error("STOP after data did not start write"); // [RULE_10]
    a_no_data_nowr: assert property (@(posedge core_clk) disable iff (reset)
        (stop_c && st.phase == SEP_WDATA && st.loaded == 7'h00 && !st.busy) |=> !st.busy)
        else $error("Write without data"); // [RULE_23]
    a_idle_quiet: assert property (@(posedge core_clk) disable iff (reset)
        (st.phase == SEP_IDLE && !start_c) |=> !sda_oe) else $error("Driven while idle"); // [RULE_05]
    a_start_phase: assert property (@(posedge core_clk) disable iff (reset)
        (start_c && !st.busy) |=> st.phase == SEP_DEVADR) else $error("START not taken"); // [RULE_04]
    a_busy_ignore: assert property (@(posedge core_clk) disable iff (reset)
        (start_c && st.busy) |=> st.phase == SEP_IGNORE) else $error("Address taken while busy"); // [RULE_14]
    a_page_fixed: assert property (@(posedge core_clk) disable iff (reset)
        (st.phase == SEP_WDATA && $past(st.phase) == SEP_WDATA)
        |-> st.addr[ADDR_W-1:OFS_W] == $past(st.addr[ADDR_W-1:OFS_W]))
        else $error("Page moved while loading"); // [RULE_13]
    a_drive_fall: assert property (@(posedge core_clk) disable iff (reset)
        $changed(sda_oe) |-> $past(scl_fall || start_c || stop_c || st.busy))
        else $error("Output changed away from clock fall"); // [RULE_01]
    a_protect_nak: assert property (@(posedge core_clk) disable iff (reset)
        (scl_fall && st.phase == SEP_WDATA && st.bitn == 4'h7 && st.protect && !start_c && !stop_c)
        |=> !sda_oe) else $error("Protected data acknowledged"); // [RULE_16]
endmodule

//--- common/sep_pkg.sv
// Purpose: Shared constants and types for the serial byte memory slave
// Assumes: 40 MHz core clock, bus clock passed through a two-stage synchroniser
// Notes:   Device type code is a parameter with an arbitrary default
package sep_pkg;
    localparam int unsigned       CORE_CLK_HZ          = 40000000;
    localparam int unsigned       INTERNAL_WRITE_TIME_MS = 5;
    localparam int unsigned       WRITE_CYCLES         = INTERNAL_WRITE_TIME_MS * (CORE_CLK_HZ / 1000);
    localparam int unsigned       MEM_BYTES            = 16384;
    localparam int unsigned       PAGE_BYTES           = 64;
    localparam int unsigned       ADDR_W               = 14;
    localparam int unsigned       OFS_W                = 6;
    localparam int unsigned       BYTE_BITS            = 8;
    localparam int unsigned       ACK_BIT              = 8;
    localparam logic [3:0]        TYPE_CODE_DEFAULT    = 4'h5; // Arbitrary value
    localparam logic [7:0]        ERASED_BYTE          = 8'hff;
    localparam logic [ADDR_W-1:0] ADDR_RESET           = 14'h0000;

    typedef enum logic [2:0] {
        SEP_IDLE   = 3'b000,
        SEP_DEVADR = 3'b001,
        SEP_ADRHI  = 3'b010,
        SEP_ADRLO  = 3'b011,
        SEP_WDATA  = 3'b100,
        SEP_RDATA  = 3'b101,
        SEP_IGNORE = 3'b110
    } sep_phase_e;

    typedef struct packed {
        logic scl;
        logic sda;
        logic wp;
    } sep_pins_s;

    typedef struct packed {
        logic sda_out;
        logic sda_oe;
    } sep_drive_s;
endpackage

//--- logic/sep_sync.sv
// Purpose: Two-stage synchroniser and edge finder for the bus pins
// Assumes: Pins are asynchronous to core_clk
// Notes:   First stage feeds only the second stage
module sep_sync
    import sep_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire sep_pkg::sep_pins_s pin,
    output sep_pkg::sep_pins_s      now,
    output sep_pkg::sep_pins_s      last
);
    typedef struct packed {
        sep_pins_s s1;
        sep_pins_s s2;
        sep_pins_s s3;
    } sep_sync_s;

    sep_sync_s st;
    sep_sync_s next_st;

    always_comb
    begin
        next_st    = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            st <= '{s1: 3'b110, s2: 3'b110, s3: 3'b110};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign now  = st.s2;
    assign last = st.s3;
endmodule

//--- tb/sep_master_model.sv
// Purpose: Behavioural bus master that makes the serial clock and drives data
// Assumes: Data wire is pulled up; a party sends zero by pulling it low
// Notes:   Every change lands 1 ns after a core clock rise; clock halves 4 cycles
module sep_master_model
(
    input  wire logic core_clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Data moves only while the clock is low
    task automatic put_bit(input logic b);
        tick(2);
        sda_low = ~b;
        tick(2);
        scl = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask

    // Released line reads high through the pull-up
    task automatic get_bit(output logic b);
        sda_low = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(3);
        b = sda_wire;
        tick(1);
        scl = 1'b0;
    endtask

    // Start, also repeated; bus idle or clock low on entry
    task automatic start();
        tick(2);
        sda_low = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask

    // Stop leaves the bus idle with the clock standing high
    task automatic stop();
        tick(2);
        sda_low = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b0;
        tick(4);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i]);
        get_bit(b);
        ack = ~b;
    endtask

    // Acknowledge asks for more, no acknowledge ends the read
    task automatic read_byte(input logic more, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            get_bit(d[i]);
        put_bit(~more);
    endtask
endmodule

//--- tb/test_sep_slave.sv
// Purpose: Self-checking bench for the serial byte memory slave
// Assumes: Short write cycle of 100 core clocks; select straps at 3'h5
// Notes:   Master model supplies every bus transfer
module test_sep_slave;
    timeunit 1ns;
    timeprecision 100ps;
    import sep_pkg::*;

    localparam logic [2:0] SEL   = 3'h5;
    localparam logic [7:0] DEV_W = {TYPE_CODE_DEFAULT, SEL, 1'b0};
    localparam logic [7:0] DEV_R = {TYPE_CODE_DEFAULT, SEL, 1'b1};

    logic      core_clk;
    logic      reset;
    logic      wp_in;
    logic      sda_out;
    logic      sda_oe;
    logic      write_busy;
    logic      scl;
    logic      sda_low;
    logic      ack;
    logic [7:0] d;
    wire logic sda_wire;
    int        errors;
    int        total_checks;
    int        cycles;

    // Open drain wire with pull-up
    assign sda_wire = ~sda_low & (sda_oe ? sda_out : 1'b1);

    sep_slave #(.WRITE_TICKS(100)) u_sep_slave (
        .core_clk(core_clk), .reset(reset), .scl_in(scl), .sda_in(sda_wire), .wp_in(wp_in),
        .addr_select_bit0(SEL[0]), .addr_select_bit1(SEL[1]), .addr_select_bit2(SEL[2]),
        .sda_out(sda_out), .sda_oe(sda_oe), .write_busy(write_busy));

    sep_master_model u_sep_master_model (
        .core_clk(core_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));

    always #12.5 core_clk = ~core_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            errors++;
            test_done();
        end
    end

    task automatic address(input logic [15:0] a);
        u_sep_master_model.start();
        u_sep_master_model.send_byte(DEV_W, ack);
        check(ack, 1'b1);
        u_sep_master_model.send_byte(a[15:8], ack);
        check(ack, 1'b1);
        u_sep_master_model.send_byte(a[7:0], ack);
        check(ack, 1'b1);
    endtask

    // Selective read of n bytes, master acknowledging all but the last
    task automatic read_at(input logic [15:0] a, input logic [7:0] exp [3], input int n);
        address(a);
        u_sep_master_model.start();
        u_sep_master_model.send_byte(DEV_R, ack);
        check(ack, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            u_sep_master_model.read_byte(i < n - 1, d);
            check(d, exp[i]);
        end
        u_sep_master_model.stop();
    endtask

    task automatic settle_idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
        check(write_busy, 1'b0);
    endtask

    task automatic t_erased();
        u_sep_master_model.start();
        u_sep_master_model.send_byte(DEV_R, ack);
        check(ack, 1'b1);
        u_sep_master_model.read_byte(1'b0, d);
        check(d, ERASED_BYTE);
        u_sep_master_model.stop();
        $display("test erased done");
    endtask

    task automatic t_page();
        address(16'hfffe);
        for (int i = 1; i <= 3; i++)
        begin
            u_sep_master_model.send_byte(8'ha0 + 8'(i), ack);
            check(ack, 1'b1);
        end
        u_sep_master_model.stop();
        repeat (4) @(posedge core_clk);
        #1;
        check(write_busy, 1'b1);
        // Bare START and STOP during commit must not lose buffered bytes
        u_sep_master_model.start();
        u_sep_master_model.stop();
        u_sep_master_model.start();
        u_sep_master_model.send_byte(DEV_W, ack);
        check(ack, 1'b0);
        u_sep_master_model.stop();
        settle_idle(120);
        read_at(16'h3ffe, '{8'ha1, 8'ha2, 8'hff}, 3);
        read_at(16'h3fc0, '{8'ha3, 8'hff, 8'hff}, 2);
        $display("test page done");
    endtask

    task automatic t_reject();
        logic [7:0] bad [2];
        bad = '{{TYPE_CODE_DEFAULT, 3'h2, 1'b0}, {~TYPE_CODE_DEFAULT, SEL, 1'b1}};
        for (int i = 0; i < 2; i++)
        begin
            u_sep_master_model.start();
            u_sep_master_model.send_byte(bad[i], ack);
            check(ack, 1'b0);
            u_sep_master_model.stop();
        end
        $display("test reject done");
    endtask

    task automatic t_protect();
        wp_in = 1'b1;
        address(16'h0100);
        u_sep_master_model.send_byte(8'h3c, ack);
        check(ack, 1'b0);
        u_sep_master_model.stop();
        wp_in = 1'b0;
        settle_idle(20);
        address(16'h0200);
        u_sep_master_model.stop();
        settle_idle(20);
        read_at(16'h0100, '{8'hff, 8'hff, 8'hff}, 2);
        $display("test protect done");
    endtask

    initial
    begin
        core_clk     = 1'b0;
        reset        = 1'b1;
        wp_in        = 1'b0;
        errors       = 0;
        total_checks = 0;
        cycles       = 0;
        repeat (10) @(posedge core_clk);
        #1;
        reset = 1'b0;
        repeat (16400) @(posedge core_clk);
        #1;
        check(write_busy, 1'b0);
        t_erased();
        t_page();
        t_reject();
        t_protect();
        test_done();
    end
endmodule
